// >>> hdl/vsc_device.sv
`timescale 1ns/1ps
`include "vsc_regs.svh"
module vsc_device (
  // Clock, reset and enable.
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_en_i,
  // Daisy chain.
  input  wire logic       chain_enable_in_i,
  output logic            chain_enable_out_o,
  // Volume state seen by the user.
  output logic            appointed_o,
  output logic            selected_o,
  output logic            pending_o,
  output logic [7:0]      vol_addr_o,
  // Flash bus.
  vsc_if.dev              bus
);
  localparam int unsigned CW = `VSC_COL_W;

  vsc_pkg::vsc_cls_t cls;                // Class of the byte on the bus.
  vsc_pkg::vsc_dst_t st_reg;             // Command phase, kept across deselection.
  logic [7:0]        buf_mem [2**CW];    // Page buffer.
  logic [CW-1:0]     col_reg;            // Column pointer.
  logic              acnt_reg;           // Set once the first address byte is taken.
  logic [1:0]        sfcnt_reg;          // Set Feature parameter byte count.
  logic [7:0]        feat_reg;           // Feature address being written.
  logic [7:0]        sfvol_reg;          // Volume address carried by Set Feature.
  logic              appointed_reg;      // A volume address exists.
  logic [7:0]        vol_reg;            // Appointed volume address.
  logic              sel_reg;            // Last selection decision.
  logic              pend_reg;           // Pending reversion decision.
  logic              vsa_reg;            // Volume Select waits for its address.
  logic              ceo_reg;            // Chain enable out.
  logic              ce_n_d_reg;         // Previous enable level.
  logic [15:0]       busy_reg;           // Array or feature busy count.
  logic [7:0]        dq_reg;             // Output data.

  vsc_cmd_decode u_dec (
    .op_i  (bus.dq_h),
    .cls_o (cls)
  );

  // Bus cycle qualifiers.
  wire wr_cyc   = clk_en_i && bus.we && !bus.ce_n;
  wire cmd_cyc  = wr_cyc && bus.cle;
  wire addr_cyc = wr_cyc && bus.ale && !bus.cle;
  wire din_cyc  = wr_cyc && !bus.ale && !bus.cle;
  wire rd_cyc   = clk_en_i && bus.re && !bus.ce_n;
  wire ce_rise  = clk_en_i && bus.ce_n && !ce_n_d_reg;
  // A Volume Select is heard in any selection state.
  wire is_vs    = cmd_cyc && cls == vsc_pkg::CL_VSEL; // R3
  // Before appointment the enable alone selects; afterwards the kept decision does.
  wire active   = !appointed_reg || sel_reg; // R5 R16 R21
  wire take_cmd = cmd_cyc && !is_vs && !vsa_reg && active; // R21
  wire take_adr = addr_cyc && !vsa_reg && active;
  wire take_din = din_cyc && active;
  wire vs_adr   = addr_cyc && vsa_reg;
  wire vs_match = bus.dq_h == vol_reg;
  wire sf_last  = take_din && st_reg == vsc_pkg::ST_SF_DATA && sfcnt_reg == `VSC_SF_BYTES;
  wire sf_vol   = feat_reg == `VSC_FA_VOLCFG;
  wire appoint  = sf_last && sf_vol;
  wire busy     = busy_reg != 16'h0;
  wire col_adr  = take_adr && !acnt_reg;
  wire dout_mode = st_reg == vsc_pkg::ST_DOUT || st_reg == vsc_pkg::ST_STAT;
  wire arr_conf = take_cmd && ((cls == vsc_pkg::CL_RD_CONF && st_reg == vsc_pkg::ST_RD_ADDR)
                  || (cls == vsc_pkg::CL_PG_CONF && st_reg == vsc_pkg::ST_DIN)
                  || (cls == vsc_pkg::CL_ER_CONF && st_reg == vsc_pkg::ST_ER_ADDR));
  wire sf_ok    = chain_enable_in_i;

  // Enable history for edge detection.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      ce_n_d_reg <= 1'b1;
    else if (clk_en_i)
      ce_n_d_reg <= bus.ce_n;
  end

  // Volume appointment; power-on reset forgets it.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      appointed_reg <= 1'b0; // R1
      vol_reg       <= 8'h00;
      ceo_reg       <= 1'b0;
    end
    else if (appoint)
    begin
      appointed_reg <= 1'b1;
      vol_reg       <= sfvol_reg;
      ceo_reg       <= 1'b1; // R18
    end
  end

  // Selection, pending reversion and the select address phase.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      sel_reg  <= 1'b0;
      pend_reg <= 1'b0;
      vsa_reg  <= 1'b0;
    end
    else if (appoint)
    begin
      // A freshly appointed volume waits to be named.
      sel_reg  <= 1'b0; // R18
      pend_reg <= 1'b0;
    end
    else if (ce_rise)
    begin
      pend_reg <= appointed_reg; // R17
      vsa_reg  <= 1'b0;
    end
    else if (is_vs && appointed_reg)
    begin
      vsa_reg  <= 1'b1;
      pend_reg <= 1'b0;
    end
    else if (vs_adr)
    begin
      sel_reg <= vs_match; // R20
      vsa_reg <= 1'b0;
    end
    else if (cmd_cyc && pend_reg)
    begin
      // First command was not a select: keep the last decision.
      pend_reg <= 1'b0; // R16
    end
  end

  // Command phase; a deselected volume leaves it untouched.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      st_reg <= vsc_pkg::ST_IDLE;
    else if (take_cmd)
    begin
      case (cls)
        vsc_pkg::CL_READ:     st_reg <= vsc_pkg::ST_RD_ADDR;
        vsc_pkg::CL_PROG:     st_reg <= vsc_pkg::ST_PG_ADDR;
        vsc_pkg::CL_ERASE:    st_reg <= vsc_pkg::ST_ER_ADDR;
        vsc_pkg::CL_SETF:     st_reg <= sf_ok ? vsc_pkg::ST_SF_ADDR : vsc_pkg::ST_IDLE;
        vsc_pkg::CL_STAT:     st_reg <= vsc_pkg::ST_STAT;
        vsc_pkg::CL_RDO:      st_reg <= vsc_pkg::ST_RDO_ADDR;
        vsc_pkg::CL_RDO_CONF: st_reg <= vsc_pkg::ST_DOUT; // R10
        vsc_pkg::CL_RD_CONF:  st_reg <= arr_conf ? vsc_pkg::ST_DOUT : vsc_pkg::ST_IDLE;
        default:              st_reg <= vsc_pkg::ST_IDLE;
      endcase
    end
    else if (take_adr && st_reg == vsc_pkg::ST_SF_ADDR)
      st_reg <= vsc_pkg::ST_SF_DATA;
    else if (take_din && st_reg == vsc_pkg::ST_PG_ADDR)
      st_reg <= vsc_pkg::ST_DIN;
    else if (sf_last)
      st_reg <= vsc_pkg::ST_IDLE;
  end

  // Address and Set Feature counters.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      acnt_reg  <= 1'b0;
      sfcnt_reg <= 2'd0;
      feat_reg  <= 8'h00;
      sfvol_reg <= 8'h00;
    end
    else
    begin
      if (take_cmd)
        acnt_reg <= 1'b0;
      else if (take_adr)
        acnt_reg <= 1'b1;
      if (take_adr && st_reg == vsc_pkg::ST_SF_ADDR)
      begin
        feat_reg  <= bus.dq_h;
        sfcnt_reg <= 2'd0;
      end
      else if (take_din && st_reg == vsc_pkg::ST_SF_DATA)
        sfcnt_reg <= sfcnt_reg + 2'd1;
      if (take_din && st_reg == vsc_pkg::ST_SF_DATA && sfcnt_reg == 2'd0)
        sfvol_reg <= bus.dq_h;
    end
  end

  // Column pointer survives a volume switch so the transfer can resume.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      col_reg <= '0;
    else if (col_adr)
      col_reg <= bus.dq_h[CW-1:0]; // R8 R9
    else if ((take_din && (st_reg == vsc_pkg::ST_PG_ADDR || st_reg == vsc_pkg::ST_DIN))
             || (rd_cyc && active && st_reg == vsc_pkg::ST_DOUT))
      col_reg <= col_reg + 1'b1;
  end

  // Page buffer write.
  always_ff @(posedge clk_sys_i)
  begin
    if (take_din && (st_reg == vsc_pkg::ST_PG_ADDR || st_reg == vsc_pkg::ST_DIN))
      buf_mem[col_reg] <= bus.dq_h;
  end

  // Busy count runs whatever the selection, so volumes work side by side.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      busy_reg <= 16'h0;
    else if (appoint)
      busy_reg <= 16'(`VSC_FEATURE_BUSY_TIME_CYC);
    else if (arr_conf)
      busy_reg <= 16'(`VSC_TARR_CYC);
    else if (busy && clk_en_i)
      busy_reg <= busy_reg - 16'h1; // R7
  end

  // Output data register.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      dq_reg <= 8'h00;
    else if (rd_cyc && active)
    begin
      if (st_reg == vsc_pkg::ST_STAT)
      begin
        dq_reg               <= 8'h00;
        dq_reg[`VSC_SR_RDY]  <= !busy;
      end
      else if (st_reg == vsc_pkg::ST_DOUT)
        dq_reg <= buf_mem[col_reg];
    end
  end

  // Drivers; a deselected volume keeps its data pins released.
  assign bus.dq_d           = dq_reg;
  // Released in host write cycles so the two ends never drive together.
  assign bus.dq_d_oe_n      = !(active && dout_mode && !bus.ce_n && !vsa_reg && !bus.we); // R21
  assign bus.rdy            = !busy;
  assign chain_enable_out_o = ceo_reg;
  assign appointed_o        = appointed_reg;
  assign selected_o         = active;
  assign pending_o          = pend_reg;
  assign vol_addr_o         = vol_reg;
endmodule

// >>> hdl/vsc_regs.svh
`ifndef VSC_REGS_SVH
`define VSC_REGS_SVH
// Notes on behaviour
// R1: Power loss forgets the appointed volume address.
// R2: Host appoints a volume after every power-on.
// R3: Enable low selects all, pending Volume Select.
// R4: Host holds enable high, then issues Volume Select.
// R5: Selected volume stays selected without further selects.
// R6: Host never broadcasts one command to volumes.
// R7: Volumes run commands concurrently and independently.
// R8: Switched-away transfers keep state for later resumption.
// R9: Data input resumes after wait and Change Row.
// R10: Data output resumes after a column change command.
// R11: Target-level data completes before another volume select.
// R12: No Volume Select inside a read sequence.
// R13: No Volume Select inside a program sequence.
// R14: Select allowed before program confirm, then wait.
// R15: No Volume Select inside an erase sequence.
// R16: Non-select first command reverts to previous selection.
// R17: Enable rising edge enters the pending reversion state.
// R18: Appointment raises chain enable out, volume deselected.
// R19: Host waits feature busy time after appointing.
// R20: Volume Select compares address: match selects, else deselects.
// R21: Deselected volume ignores commands and releases data.

// Clock period in nanoseconds.
`define VSC_CLK_NS 10
// Least enable high time and its cycle count, rounded up.
`define VSC_ENABLE_HIGH_MIN_TIME_NS 20
`define VSC_ENABLE_HIGH_MIN_TIME_CYC ((`VSC_ENABLE_HIGH_MIN_TIME_NS + `VSC_CLK_NS - 1) / `VSC_CLK_NS)
// Least column change setup time and its cycle count.
`define VSC_CHANGE_COLUMN_SETUP_TIME_NS 300
`define VSC_CHANGE_COLUMN_SETUP_TIME_CYC ((`VSC_CHANGE_COLUMN_SETUP_TIME_NS + `VSC_CLK_NS - 1) / `VSC_CLK_NS)
// Feature busy time and its cycle count.
`define VSC_FEATURE_BUSY_TIME_NS 1000
`define VSC_FEATURE_BUSY_TIME_CYC ((`VSC_FEATURE_BUSY_TIME_NS + `VSC_CLK_NS - 1) / `VSC_CLK_NS)
// Array busy time after a read, program or erase confirm.
`define VSC_TARR_NS 200
`define VSC_TARR_CYC ((`VSC_TARR_NS + `VSC_CLK_NS - 1) / `VSC_CLK_NS)

// Opcodes.
`define VSC_OP_READ 8'h00
`define VSC_OP_RD_C0 8'h30
`define VSC_OP_RD_C1 8'h31
`define VSC_OP_RD_C2 8'h32
`define VSC_OP_RD_C3 8'h35
`define VSC_OP_PG_0 8'h80
`define VSC_OP_PG_1 8'h81
`define VSC_OP_PG_2 8'h85
`define VSC_OP_PG_C0 8'h10
`define VSC_OP_PG_C1 8'h11
`define VSC_OP_PG_C2 8'h15
`define VSC_OP_ER 8'h60
`define VSC_OP_ER_C0 8'hd0
`define VSC_OP_ER_C1 8'hd1
`define VSC_OP_VSEL 8'he1
`define VSC_OP_SETF 8'hef
`define VSC_OP_STAT 8'h70
`define VSC_OP_RDO 8'h05
`define VSC_OP_RDO_E 8'h06
`define VSC_OP_RDO_C 8'he0
// Feature address of the volume configuration feature.
`define VSC_FA_VOLCFG 8'h58
// Index of the last Set Feature parameter byte.
`define VSC_SF_BYTES 2'd3
// Ready bit of the status byte.
`define VSC_SR_RDY 6
// Page buffer depth and column width.
`define VSC_COL_W 4
`endif

// >>> hdl/vsc_pkg.sv
package vsc_pkg;
  // Opcode classes.
  typedef enum logic [3:0] {
    CL_OTHER = 4'h0, CL_READ = 4'h1, CL_RD_CONF = 4'h2, CL_PROG = 4'h3,
    CL_PG_CONF = 4'h4, CL_ERASE = 4'h5, CL_ER_CONF = 4'h6, CL_VSEL = 4'h7,
    CL_SETF = 4'h8, CL_STAT = 4'h9, CL_RDO = 4'ha, CL_RDO_CONF = 4'hb
  } vsc_cls_t;
  // Device command phases.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_RD_ADDR = 4'h1, ST_DOUT = 4'h2, ST_PG_ADDR = 4'h3,
    ST_DIN = 4'h4, ST_ER_ADDR = 4'h5, ST_SF_ADDR = 4'h6, ST_SF_DATA = 4'h7,
    ST_STAT = 4'h8, ST_RDO_ADDR = 4'h9
  } vsc_dst_t;
  // Host request kinds.
  typedef enum logic [2:0] {
    HK_CMD = 3'h0, HK_ADDR = 3'h1, HK_DIN = 3'h2, HK_DOUT = 3'h3,
    HK_VSEL = 3'h4, HK_APPOINT = 3'h5, HK_CEHI = 3'h6
  } vsc_kind_t;
  // Host sequencer states.
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_CEH = 3'h1, HS_VS_CMD = 3'h2, HS_VS_ADDR = 3'h3,
    HS_SF = 3'h4, HS_WAIT = 3'h5, HS_RD = 3'h6
  } vsc_hst_t;
endpackage

// >>> hdl/vsc_if.sv
`timescale 1ns/1ps
interface vsc_if;
  logic       ce_n;      // Shared target enable, active low.
  logic       cle;       // Command cycle qualifier.
  logic       ale;       // Address cycle qualifier.
  logic       we;        // One-cycle write strobe.
  logic       re;        // One-cycle read strobe.
  logic [7:0] dq_h;      // Host data toward the device.
  logic       dq_h_oe_n; // Host drives dq while low.
  logic [7:0] dq_d;      // Device data toward the host.
  logic       dq_d_oe_n; // Device drives dq while low.
  logic       rdy;       // Device ready level.
  // Resolved data wire as seen on the shared bus.
  wire [7:0] dq = !dq_d_oe_n ? dq_d : (!dq_h_oe_n ? dq_h : 8'hff);
  modport dev (input ce_n, cle, ale, we, re, dq_h, output dq_d, dq_d_oe_n, rdy);
  modport host (output ce_n, cle, ale, we, re, dq_h, dq_h_oe_n, input dq_d, dq_d_oe_n, rdy);
endinterface

// >>> hdl/vsc_cmd_decode.sv
`timescale 1ns/1ps
`include "vsc_regs.svh"
module vsc_cmd_decode (
  // Opcode in.
  input  wire logic [7:0]        op_i,
  // Class out.
  output vsc_pkg::vsc_cls_t      cls_o
);
  // Sorts an opcode into the class the sequencers act on.
  always_comb
  begin
    case (op_i)
      `VSC_OP_READ: cls_o = vsc_pkg::CL_READ;
      `VSC_OP_RD_C0, `VSC_OP_RD_C1, `VSC_OP_RD_C2, `VSC_OP_RD_C3: cls_o = vsc_pkg::CL_RD_CONF;
      `VSC_OP_PG_0, `VSC_OP_PG_1, `VSC_OP_PG_2: cls_o = vsc_pkg::CL_PROG;
      `VSC_OP_PG_C0, `VSC_OP_PG_C1, `VSC_OP_PG_C2: cls_o = vsc_pkg::CL_PG_CONF;
      `VSC_OP_ER: cls_o = vsc_pkg::CL_ERASE;
      `VSC_OP_ER_C0, `VSC_OP_ER_C1: cls_o = vsc_pkg::CL_ER_CONF;
      `VSC_OP_VSEL: cls_o = vsc_pkg::CL_VSEL;
      `VSC_OP_SETF: cls_o = vsc_pkg::CL_SETF;
      `VSC_OP_STAT: cls_o = vsc_pkg::CL_STAT;
      `VSC_OP_RDO, `VSC_OP_RDO_E: cls_o = vsc_pkg::CL_RDO;
      `VSC_OP_RDO_C: cls_o = vsc_pkg::CL_RDO_CONF;
      default: cls_o = vsc_pkg::CL_OTHER;
    endcase
  end
endmodule

// >>> hdl/vsc_host.sv
`timescale 1ns/1ps
`include "vsc_regs.svh"
module vsc_host (
  // Clock, reset and enable.
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_en_i,
  // Request.
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  vsc_pkg::vsc_kind_t     req_kind_i,
  input  wire logic [7:0]        req_byte_i,
  // Answer.
  output logic                   resp_valid_o,
  output logic [7:0]             resp_data_o,
  output logic                   req_err_o,
  // Flash bus.
  vsc_if.host                    bus
);
  vsc_pkg::vsc_hst_t st_reg;    // Sequencer state.
  vsc_pkg::vsc_cls_t cls;       // Class of the requested byte.
  logic [15:0]       cnt_reg;   // Wait and byte counter.
  logic [7:0]        byte_reg;  // Byte held for a sequence.
  logic              atom_reg;  // Inside an unbreakable sequence.
  logic              prog_reg;  // Program data input open.
  logic              ce_n_reg, cle_reg, ale_reg, we_reg, re_reg, oe_n_reg;
  logic [7:0]        dq_reg;
  logic              rv_reg, err_reg;
  logic [7:0]        rd_reg;

  vsc_cmd_decode u_dec (
    .op_i  (req_byte_i),
    .cls_o (cls)
  );

  wire take    = clk_en_i && req_valid_i && req_ready_o;
  wire is_vs   = req_kind_i == vsc_pkg::HK_VSEL;
  // A select inside read, erase or pre-data program is refused.
  wire vs_bad  = is_vs && atom_reg && !prog_reg; // R12 R13 R15
  wire opens   = cls == vsc_pkg::CL_READ || cls == vsc_pkg::CL_PROG || cls == vsc_pkg::CL_ERASE;
  wire closes  = cls == vsc_pkg::CL_RD_CONF || cls == vsc_pkg::CL_PG_CONF || cls == vsc_pkg::CL_ER_CONF;
  wire cnt_end = cnt_reg == 16'h0;

  assign req_ready_o = st_reg == vsc_pkg::HS_IDLE;

  // Tracks open sequences so selects land only where allowed.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      atom_reg <= 1'b0;
      prog_reg <= 1'b0;
    end
    else if (take && req_kind_i == vsc_pkg::HK_CMD)
    begin
      atom_reg <= opens;
      prog_reg <= 1'b0;
    end
    else if (take && req_kind_i == vsc_pkg::HK_DIN && atom_reg)
      prog_reg <= 1'b1;
  end

  // Sequencer and bus cycle generation.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= vsc_pkg::HS_IDLE;
      cnt_reg <= 16'h0;
      byte_reg <= 8'h00;
      ce_n_reg <= 1'b1;
      {cle_reg, ale_reg, we_reg, re_reg, rv_reg, err_reg} <= 6'h0;
      oe_n_reg <= 1'b1;
      dq_reg <= 8'h00;
      rd_reg <= 8'h00;
    end
    else if (clk_en_i)
    begin
      {cle_reg, ale_reg, we_reg, re_reg, rv_reg, err_reg} <= 6'h0;
      oe_n_reg <= 1'b1;
      case (st_reg)
        vsc_pkg::HS_IDLE:
        begin
          if (take && vs_bad)
            err_reg <= 1'b1;
          else if (take)
          begin
            byte_reg <= req_byte_i;
            case (req_kind_i)
              vsc_pkg::HK_CEHI: ce_n_reg <= 1'b1; // R17
              vsc_pkg::HK_VSEL:
              begin
                ce_n_reg <= 1'b1; // R4
                cnt_reg  <= 16'(`VSC_ENABLE_HIGH_MIN_TIME_CYC);
                st_reg   <= vsc_pkg::HS_CEH;
              end
              vsc_pkg::HK_APPOINT:
              begin
                ce_n_reg <= 1'b0; // R2
                {cle_reg, we_reg, oe_n_reg} <= 3'b110;
                dq_reg   <= `VSC_OP_SETF;
                cnt_reg  <= 16'h0;
                st_reg   <= vsc_pkg::HS_SF;
              end
              vsc_pkg::HK_DOUT:
              begin
                ce_n_reg <= 1'b0;
                re_reg   <= 1'b1;
                st_reg   <= vsc_pkg::HS_RD;
              end
              default:
              begin
                // One write cycle to the single selected volume.
                ce_n_reg <= 1'b0; // R6
                we_reg   <= 1'b1;
                oe_n_reg <= 1'b0;
                cle_reg  <= req_kind_i == vsc_pkg::HK_CMD;
                ale_reg  <= req_kind_i == vsc_pkg::HK_ADDR;
                dq_reg   <= req_byte_i;
              end
            endcase
          end
        end
        vsc_pkg::HS_CEH:
        begin
          if (cnt_reg <= 16'h1)
          begin
            ce_n_reg <= 1'b0;
            st_reg   <= vsc_pkg::HS_VS_CMD;
          end
          else
            cnt_reg <= cnt_reg - 16'h1;
        end
        vsc_pkg::HS_VS_CMD:
        begin
          {cle_reg, we_reg, oe_n_reg} <= 3'b110;
          dq_reg <= `VSC_OP_VSEL;
          st_reg <= vsc_pkg::HS_VS_ADDR;
        end
        vsc_pkg::HS_VS_ADDR:
        begin
          {ale_reg, we_reg, oe_n_reg} <= 3'b110;
          dq_reg  <= byte_reg;
          // Suspended data input needs the column setup wait.
          cnt_reg <= prog_reg ? 16'(`VSC_CHANGE_COLUMN_SETUP_TIME_CYC) : 16'h0; // R9 R14
          st_reg  <= vsc_pkg::HS_WAIT;
        end
        vsc_pkg::HS_SF:
        begin
          // Feature address, then volume address and zero padding.
          we_reg   <= 1'b1;
          oe_n_reg <= 1'b0;
          ale_reg  <= cnt_reg == 16'h0;
          dq_reg   <= cnt_reg == 16'h0 ? `VSC_FA_VOLCFG : (cnt_reg == 16'h1 ? byte_reg : 8'h00);
          if (cnt_reg == 16'h4)
          begin
            cnt_reg <= 16'(`VSC_FEATURE_BUSY_TIME_CYC); // R11 R19
            st_reg  <= vsc_pkg::HS_WAIT;
          end
          else
            cnt_reg <= cnt_reg + 16'h1;
        end
        vsc_pkg::HS_WAIT:
        begin
          if (cnt_end)
            st_reg <= vsc_pkg::HS_IDLE;
          else
            cnt_reg <= cnt_reg - 16'h1;
        end
        vsc_pkg::HS_RD:
        begin
          // The device loads its data on the strobe edge, so take it one edge later.
          if (!re_reg)
          begin
            rd_reg <= bus.dq_d;
            rv_reg <= 1'b1;
            st_reg <= vsc_pkg::HS_IDLE;
          end
        end
        default: st_reg <= vsc_pkg::HS_IDLE;
      endcase
      if (take && closes && req_kind_i == vsc_pkg::HK_CMD && !vs_bad)
        byte_reg <= req_byte_i;
    end
  end

  // Bus and answer drivers.
  assign bus.ce_n      = ce_n_reg;
  assign bus.cle       = cle_reg;
  assign bus.ale       = ale_reg;
  assign bus.we        = we_reg;
  assign bus.re        = re_reg;
  assign bus.dq_h      = dq_reg;
  assign bus.dq_h_oe_n = oe_n_reg;
  assign resp_valid_o  = rv_reg;
  assign resp_data_o   = rd_reg;
  assign req_err_o     = err_reg;
endmodule

// >>> dv/vsc_assertions.sv
`timescale 1ns/1ps
`include "vsc_regs.svh"
module vsc_assertions (
  // Clock and reset.
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  // Bus signals.
  input wire logic       ce_n,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       we,
  input wire logic [7:0] dq_h,
  input wire logic       dq_h_oe_n,
  input wire logic       dq_d_oe_n,
  input wire logic       rdy
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Command and data writes seen on the bus.
  wire        cmd_w = we && cle && !ce_n;
  wire        din_w = we && !cle && !ale && !ce_n;
  wire        vsel  = cmd_w && (dq_h == `VSC_OP_VSEL);
  logic [2:0] open_reg;  // Open program without data, erase, read.
  logic       sf_reg;    // Last command was Set Feature.
  logic [7:0] quiet_reg; // Cycles left in the appointment wait.
  // Tracks the atomic sequences and the wait after appointment.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      open_reg  <= 3'h0;
      sf_reg    <= 1'b0;
      quiet_reg <= 8'h00;
    end
    else
    begin
      if (cmd_w && !vsel)
        open_reg <= {dq_h == 8'h80 || dq_h == 8'h81 || dq_h == 8'h85, dq_h == 8'h60, dq_h == 8'h00};
      else if (din_w)
        open_reg[2] <= 1'b0;
      sf_reg    <= cmd_w ? (dq_h == `VSC_OP_SETF) : sf_reg;
      quiet_reg <= (sf_reg && $fell(rdy)) ? 8'(`VSC_FEATURE_BUSY_TIME_CYC) : quiet_reg - {7'h00, quiet_reg != 8'h00};
    end
  end
  sequence ce_rise_s; $rose(ce_n); endsequence
  sequence ce_hold_s; ce_n [*2]; endsequence
  AST_CE_HIGH_MIN: assert property (ce_rise_s |-> ce_hold_s) else $error("enable high too short");
  AST_VSEL_AFTER_CE: assert property (vsel |-> $past(ce_n) || $past(ce_n, 2)) else $error("select without enable high");
  AST_NO_VSEL_READ: assert property (vsel |-> !open_reg[0]) else $error("select inside read");
  AST_NO_VSEL_ERASE: assert property (vsel |-> !open_reg[1]) else $error("select inside erase");
  AST_NO_VSEL_PROG: assert property (vsel |-> !open_reg[2]) else $error("select inside program");
  AST_DOUT_NEEDS_CE: assert property (!dq_d_oe_n |-> !ce_n) else $error("device drives while disabled");
  AST_NO_CONTENTION: assert property (!(!dq_d_oe_n && !dq_h_oe_n)) else $error("both drive data");
  AST_APPOINT_QUIET: assert property (quiet_reg != 8'h00 |-> !we) else $error("write during feature busy");
  AST_RESET_IDLE: assert property ($rose(rst_n_i) |-> dq_d_oe_n && rdy && ce_n && !we) else $error("bad idle");
endmodule

// >>> dv/volume_select_control_test.sv
`timescale 1ns/1ps
module volume_select_control_test;
  logic               clk_sys_i = 1'b0;
  logic               rst_n_i = 1'b0;
  logic               chain_in = 1'b0;
  logic               req_valid_i = 1'b0;
  vsc_pkg::vsc_kind_t req_kind_i = vsc_pkg::HK_CMD;
  logic [7:0]         req_byte_i = 8'h00;
  logic               req_ready_o, resp_valid_o, req_err_o, ceo, appointed, selected, pending;
  logic [7:0]         resp_data_o, vol_addr, last_resp;
  int                 mismatches = 0;
  int                 n_tests = 0;
  int                 cycles = 0;
  int                 errs = 0;
  int                 drives = 0;
  vsc_if bus ();
  vsc_device u_vsc_device (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .chain_enable_in_i(chain_in),
    .chain_enable_out_o(ceo), .appointed_o(appointed), .selected_o(selected), .pending_o(pending),
    .vol_addr_o(vol_addr), .bus(bus.dev));
  vsc_host u_vsc_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_kind_i(req_kind_i), .req_byte_i(req_byte_i), .resp_valid_o(resp_valid_o),
    .resp_data_o(resp_data_o), .req_err_o(req_err_o), .bus(bus.host));
  vsc_assertions u_vsc_assertions (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_n(bus.ce_n), .cle(bus.cle),
    .ale(bus.ale), .we(bus.we), .dq_h(bus.dq_h), .dq_h_oe_n(bus.dq_h_oe_n), .dq_d_oe_n(bus.dq_d_oe_n),
    .rdy(bus.rdy));
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Counts cycles, refusals, device drive cycles and keeps the last read byte.
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (req_err_o === 1'b1) errs++;
    if (bus.dq_d_oe_n === 1'b0) drives++;
    if (resp_valid_o === 1'b1) last_resp <= resp_data_o;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Done: %0d compares, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds one request from a falling edge until a rising edge sees ready high.
  task automatic req(input vsc_pkg::vsc_kind_t k, input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    req_valid_i = 1'b1;
    req_kind_i = k;
    req_byte_i = b;
    while (req_ready_o !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
  endtask
  // Waits until the host is idle and the device ready.
  task automatic wt();
    int n;
    n = 0;
    repeat (3) @(negedge clk_sys_i);
    while (!(req_ready_o === 1'b1 && bus.rdy === 1'b1) && n < 300)
    begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask
  task automatic t_power();
    chk({6'h00, ceo, appointed}, 8'h00);
    req(vsc_pkg::HK_APPOINT, 8'h05);
    wt();
    chk({7'h00, appointed}, 8'h00);
    chain_in = 1'b1;
    req(vsc_pkg::HK_APPOINT, 8'h05);
    wt();
    chk({5'h00, ceo, appointed, selected}, 8'h06);
    chk(vol_addr, 8'h05);
    $display("power test done");
  endtask
  task automatic t_select();
    int d;
    req(vsc_pkg::HK_VSEL, 8'h03);
    wt();
    chk({7'h00, selected}, 8'h00);
    req(vsc_pkg::HK_VSEL, 8'h05);
    req(vsc_pkg::HK_CMD, 8'h70);
    req(vsc_pkg::HK_DOUT, 8'h00);
    wt();
    chk(last_resp & 8'h40, 8'h40);
    chk({7'h00, selected}, 8'h01);
    req(vsc_pkg::HK_VSEL, 8'h03);
    wt();
    d = drives;
    req(vsc_pkg::HK_CMD, 8'h70);
    req(vsc_pkg::HK_DOUT, 8'h00);
    wt();
    chk(8'(drives - d), 8'h00);
    req(vsc_pkg::HK_CEHI, 8'h00);
    wt();
    chk({7'h00, pending}, 8'h01);
    req(vsc_pkg::HK_CMD, 8'h70);
    wt();
    chk({6'h00, pending, selected}, 8'h00);
    req(vsc_pkg::HK_VSEL, 8'h05);
    req(vsc_pkg::HK_CEHI, 8'h00);
    req(vsc_pkg::HK_CMD, 8'h70);
    wt();
    chk({7'h00, selected}, 8'h01);
    $display("select test done");
  endtask
  task automatic t_refuse();
    logic [7:0] op [3] = '{8'h00, 8'h60, 8'h80};
    logic [7:0] cf [3] = '{8'h30, 8'hd0, 8'h10};
    int e;
    for (int i = 0; i < 3; i++)
    begin
      req(vsc_pkg::HK_CMD, op[i]);
      req(vsc_pkg::HK_ADDR, 8'h00);
      e = errs;
      req(vsc_pkg::HK_VSEL, 8'h05);
      wt();
      chk(8'(errs - e), 8'h01);
      req(vsc_pkg::HK_CMD, cf[i]);
      wt();
    end
    $display("refuse test done");
  endtask
  task automatic t_resume();
    int e;
    req(vsc_pkg::HK_CMD, 8'h80);
    req(vsc_pkg::HK_ADDR, 8'h03);
    req(vsc_pkg::HK_DIN, 8'h11);
    e = errs;
    req(vsc_pkg::HK_VSEL, 8'h03);
    req(vsc_pkg::HK_VSEL, 8'h05);
    wt();
    chk(8'(errs - e), 8'h00);
    req(vsc_pkg::HK_CMD, 8'h85);
    req(vsc_pkg::HK_ADDR, 8'h04);
    req(vsc_pkg::HK_DIN, 8'h22);
    req(vsc_pkg::HK_CMD, 8'h10);
    wt();
    req(vsc_pkg::HK_CMD, 8'h00);
    req(vsc_pkg::HK_ADDR, 8'h03);
    req(vsc_pkg::HK_CMD, 8'h30);
    wt();
    req(vsc_pkg::HK_DOUT, 8'h00);
    wt();
    chk(last_resp, 8'h11);
    req(vsc_pkg::HK_VSEL, 8'h03);
    req(vsc_pkg::HK_VSEL, 8'h05);
    req(vsc_pkg::HK_CMD, 8'h05);
    req(vsc_pkg::HK_ADDR, 8'h04);
    req(vsc_pkg::HK_CMD, 8'he0);
    req(vsc_pkg::HK_DOUT, 8'h00);
    wt();
    chk(last_resp, 8'h22);
    $display("resume test done");
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_power();
    t_select();
    t_refuse();
    t_resume();
    finish_test();
  end
endmodule
